// ==== acc_control.sv ====
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// R1: Byte bit 7 picks setup or configuration
// R2: Bits 6..5 scan selector, reset 00
// R3: Bits 4..1 channel, four-channel upper bits zero
// R4: Bit 0 single-ended, reset one
// R5: Power-up: single-ended channel 0, supply reference
// R6: Master ignores result memory before conversion
// R7: Select 100 powers analog down when idle
// R8: External clock mode needs STOP for idle
// R9: Internal clock: power down after results written
// R10: Results served until STOP or repeated START
// R11: Valid address wakes device without delay
// R12: Middle select bit: shared pin reads ground
// R13: Master waits for reference settling
// R14: Always-on reference stays until select rewritten
// R15: Single-ended codes 0..11, upper codes reserved
// R16: Pseudo-differential adjacent pairs, odd reverses polarity
// R17: Last pair with shared pin uses ground
// R18: Differential scan follows channel bit 0
// R19: Scan 00 upward, scan 01 eight times
// R20: External clock: 01 and 11 repeat until NACK
// R21: Fields change only on complete acknowledged bytes
module acc_control
  import acc_pkg::*;
#(
  parameter int NUM_CHANNELS = 12,
  parameter int RESULT_DEPTH = 12
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset_n,
  // Decoded serial bus events
  input  wire logic       i_byte_valid,
  input  wire logic [7:0] i_byte_data,
  input  wire logic       i_addr_valid,
  input  wire logic       i_addr_read,
  input  wire logic       i_stop,
  input  wire logic       i_restart,
  input  wire logic       i_master_nack,
  // Setup fields and converter
  input  wire logic [2:0] i_ref_select,
  input  wire logic       i_ext_clock,
  input  wire logic       i_conv_done,
  // Configuration view
  output logic [1:0]      o_scan_mode,
  output logic [3:0]      o_channel_select,
  output logic            o_single_ended,
  output logic            o_setup_strobe,
  output logic [7:0]      o_setup_data,
  // Converter control
  output logic            o_conv_req,
  output logic [3:0]      o_pos_input,
  output logic [3:0]      o_neg_input,
  output logic [3:0]      o_write_index,
  output logic            o_reserved_code,
  // Power and results
  output logic            o_analog_on,
  output logic            o_ref_on,
  output logic            o_results_ready
);

  localparam logic [3:0] SHARED     = 4'(NUM_CHANNELS - 1);
  localparam logic [3:0] LAST_INDEX = 4'(RESULT_DEPTH - 1);

  // Refuse unsupported sizes
  if (!(NUM_CHANNELS == 4 || NUM_CHANNELS == 12)
      || RESULT_DEPTH < 1 || RESULT_DEPTH > 16) begin : g_bad_size
    $error("acc_control: unsupported channel count or result depth");
  end

  acc_regs_s r_reg;
  acc_regs_s r_next;

  // Channel selector of a configuration
  function automatic logic [3:0] cs_of(input acc_cfg_s c);
    cs_of = {c.channel_select_b3, c.channel_select_b2,
             c.channel_select_b1, c.channel_select_b0};
  endfunction

  // Positive and negative input of a code
  function automatic logic [7:0] route(input logic [3:0] code, input logic sgl,
                                       input logic mid);
    logic [3:0] p;
    logic [3:0] m;
    p = code;
    m = sgl ? CH_GND : (code ^ 4'h1);
    if (mid && p == SHARED) p = CH_GND;
    if (mid && m == SHARED) m = CH_GND;
    route = {p, m};
  endfunction

  // Code that touches the shared pin
  function automatic logic excluded(input logic [3:0] code, input logic sgl,
                                    input logic mid);
    excluded = mid && (sgl ? (code == SHARED) : (code[3:1] == SHARED[3:1]));
  endfunction

  // Next state
  always_comb begin
    logic [3:0] cs;
    logic [3:0] mid_start;
    logic [3:0] step;
    logic [3:0] nxt;
    logic       mid;
    logic       auto;
    logic       always_on;
    cs        = cs_of(r_reg.cfg);
    mid_start = (NUM_CHANNELS == 4) ? MID_START_4 : MID_START_12;
    step      = r_reg.sgl ? 4'h1 : 4'h2;
    nxt       = r_reg.code + step;
    mid       = i_ref_select[SEL_MID_BIT];
    auto      = (i_ref_select == SEL_AUTO_DOWN);
    always_on = (i_ref_select == SEL_INT_ON) || (i_ref_select[2:1] == SEL_HI_OUTPUT);
    r_next    = r_reg;
    r_next.setup_strobe = 1'b0;

    // R21: whole acknowledged bytes only
    if (i_byte_valid) begin
      // R1: type bit routes the byte
      if (i_byte_data[BYTE_TYPE_BIT]) begin
        r_next.setup_strobe = 1'b1;
        r_next.setup_data   = i_byte_data;
      end else begin
        // R2: scan selector from bits 6..5
        r_next.cfg = acc_cfg_s'(i_byte_data[6:0]);
        // R3: four-channel upper bits held zero
        if (NUM_CHANNELS == 4) begin
          r_next.cfg.channel_select_b3 = 1'b0;
          r_next.cfg.channel_select_b2 = 1'b0;
        end
      end
    end

    unique case (r_reg.state)
      ST_IDLE: begin
        if (i_addr_valid && i_addr_read) begin
          r_next.sgl   = r_reg.cfg.single_ended_select;
          r_next.multi = !r_reg.cfg.scan_select_lo;
          r_next.first = cs;
          r_next.last  = cs;
          r_next.reps_load = 4'h1;
          if (!r_reg.cfg.single_ended_select) mid_start[0] = cs[0];
          unique case ({r_reg.cfg.scan_select_hi, r_reg.cfg.scan_select_lo})
            // R19: upward scan from channel 0
            // R18: differential start by bit 0
            SCAN_UPWARD: begin
              r_next.first = r_reg.cfg.single_ended_select ? 4'h0 : {3'h0, cs[0]};
            end
            // R20: external clock repeats until NACK, STOP or restart
            // R19: eight repeats on internal clock
            SCAN_REPEAT8: begin
              if (!i_ext_clock) r_next.reps_load = REPEAT_COUNT;
            end
            SCAN_FROM_MID: begin
              r_next.first = mid_start;
              if (cs < mid_start) r_next.last = mid_start;
            end
            SCAN_SINGLE: begin
              r_next.reps_load = 4'h1;
            end
          endcase
          r_next.code = r_next.first;
          r_next.reps = r_next.reps_load;
          // R15: upper codes reserved
          // R16: reserved in both modes
          r_next.reserved_code = (cs > CODE_LAST_VALID);
          if (cs <= CODE_LAST_VALID) begin
            r_next.state    = ST_CONV;
            r_next.conv_req = 1'b1;
          end
        end
      end
      ST_CONV: begin
        if (i_conv_done) begin
          r_next.wr_index = (r_reg.wr_index == LAST_INDEX) ? 4'h0 : r_reg.wr_index + 4'h1;
          if (r_reg.reps > 4'h1) begin
            r_next.reps = r_reg.reps - 4'h1;
          end else if (r_reg.code >= r_reg.last
                       || (r_reg.multi && excluded(nxt, r_reg.sgl, mid))) begin
            if (i_ext_clock) begin
              r_next.code = r_reg.first;
              r_next.reps = r_reg.reps_load;
            end else begin
              r_next.state         = ST_IDLE;
              r_next.conv_req      = 1'b0;
              r_next.results_ready = 1'b1;
              // R9: power down once results stored
              if (auto) r_next.analog_on = 1'b0;
            end
          end else begin
            r_next.code = nxt;
            r_next.reps = r_reg.reps_load;
          end
        end
        // R20: NACK or bus end stops conversions
        if (i_master_nack || i_stop || i_restart) begin
          r_next.state    = ST_IDLE;
          r_next.conv_req = 1'b0;
        end
      end
    endcase

    // R12: shared pin converts as ground
    // R17: last pair against ground
    {r_next.pos, r_next.neg} = route(r_next.code, r_next.sgl, mid);

    // R10: results held until STOP or restart
    if (i_stop || i_restart) r_next.results_ready = 1'b0;
    if (r_reg.state == ST_IDLE && r_next.state == ST_CONV && i_ext_clock)
      r_next.results_ready = 1'b1;

    // R7: analog power follows idle in auto mode
    // R11: address wakes with no delay
    if (!auto || i_addr_valid) r_next.analog_on = 1'b1;
    else if (i_stop) r_next.analog_on = 1'b0;

    // R14: always-on reference held by select
    r_next.ref_on = always_on || (auto && r_next.analog_on);
  end

  // State register
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      // R5: power-up defaults
      r_reg               <= '0;
      r_reg.state         <= ST_IDLE;
      // R4: single-ended at reset
      r_reg.cfg           <= CFG_RESET;
      r_reg.sgl           <= 1'b1;
      r_reg.reps          <= 4'h1;
      r_reg.reps_load     <= 4'h1;
      r_reg.neg           <= CH_GND;
      r_reg.analog_on     <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state
  assign o_scan_mode      = {r_reg.cfg.scan_select_hi, r_reg.cfg.scan_select_lo};
  assign o_channel_select = cs_of(r_reg.cfg);
  assign o_single_ended   = r_reg.cfg.single_ended_select;
  assign o_setup_strobe   = r_reg.setup_strobe;
  assign o_setup_data     = r_reg.setup_data;
  assign o_conv_req       = r_reg.conv_req;
  assign o_pos_input      = r_reg.pos;
  assign o_neg_input      = r_reg.neg;
  assign o_write_index    = r_reg.wr_index;
  assign o_reserved_code  = r_reg.reserved_code;
  assign o_analog_on      = r_reg.analog_on;
  assign o_ref_on         = r_reg.ref_on;
  assign o_results_ready  = r_reg.results_ready;

  // Checks on the control behaviour
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  a_cfg_hold_partial: assert property ( // R21
    !i_byte_valid |=> $stable(r_reg.cfg))
    else $error("configuration changed without a byte");

  a_type_bit_route: assert property ( // R1
    i_byte_valid && i_byte_data[7] |=> o_setup_strobe && $stable(r_reg.cfg)
      && o_setup_data == $past(i_byte_data))
    else $error("setup byte not routed to setup");

  a_four_ch_upper: assert property ( // R3
    NUM_CHANNELS != 4 || o_channel_select[3:2] == 2'h0)
    else $error("upper channel bits not zero");

  a_wake_on_addr: assert property ( // R11
    i_addr_valid |=> o_analog_on)
    else $error("no wake on valid address");

  a_auto_stop_down: assert property ( // R7
    i_ref_select == SEL_AUTO_DOWN && i_stop && !i_addr_valid |=> !o_analog_on)
    else $error("analog still on after idle stop");

  a_internal_done_down: assert property ( // R9
    r_reg.state == ST_CONV && i_conv_done && !i_ext_clock && r_reg.reps == 4'h1
      && r_reg.code >= r_reg.last && i_ref_select == SEL_AUTO_DOWN && !i_addr_valid
      && !i_stop && !i_restart
      |=> !o_analog_on && o_results_ready && !o_conv_req)
    else $error("no power down after last result");

  a_shared_is_gnd: assert property ( // R12
    o_conv_req && $past(i_ref_select[SEL_MID_BIT]) |-> o_pos_input != SHARED
      && o_neg_input != SHARED)
    else $error("shared pin converted while used as reference");

  a_results_kept: assert property ( // R10
    o_results_ready && !i_stop && !i_restart |=> o_results_ready)
    else $error("results dropped before stop");

  a_pair_polarity: assert property ( // R16
    o_conv_req && !r_reg.sgl && !$past(i_ref_select[SEL_MID_BIT])
      |-> o_neg_input == (o_pos_input ^ 4'h1))
    else $error("pseudo-differential pair wrong");

  a_single_vs_gnd: assert property ( // R15
    o_conv_req && r_reg.sgl |-> o_neg_input == CH_GND)
    else $error("single-ended not against ground");

endmodule
`default_nettype wire

// ==== acc_master_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Event-level model of the serial bus master
module acc_master_model (
  // Clock
  input  wire logic       i_clock,
  // Bus events toward the device
  output var  logic       o_byte_valid,
  output var  logic [7:0] o_byte_data,
  output var  logic       o_addr_valid,
  output var  logic       o_addr_read,
  output var  logic       o_stop,
  output var  logic       o_restart,
  output var  logic       o_nack
);
  // Quiet bus at start
  initial begin
    {o_byte_valid, o_addr_valid, o_addr_read, o_stop, o_restart, o_nack} = 6'h00;
    o_byte_data = 8'h00;
  end
  // One-cycle event, data inverted once released
  task automatic put(input logic [4:0] e, input logic [7:0] d);
    @(negedge i_clock);
    {o_byte_valid, o_addr_valid, o_stop, o_restart, o_nack} = e;
    o_byte_data = d;
    @(negedge i_clock);
    {o_byte_valid, o_addr_valid, o_stop, o_restart, o_nack} = 5'h00;
    o_byte_data = ~d;
  endtask
  // Control byte, optionally without valid
  task automatic write_byte(input logic [7:0] d, input logic v);
    put({v, 4'h0}, d);
  endtask
  task automatic read_addr(input logic r);
    o_addr_read = r;
    put(5'h08, 8'h00);
    o_addr_read = ~r;
  endtask
  task automatic stop_cond();
    put(5'h04, 8'h00);
  endtask
  // Repeated start
  task automatic restart_ev();
    put(5'h02, 8'h00);
  endtask
  // Master declines further data
  task automatic nack_ev();
    put(5'h01, 8'h00);
  endtask
endmodule
`default_nettype wire

// ==== acc_pkg.sv ====
package acc_pkg;

  // Control byte layout
  localparam int         BYTE_TYPE_BIT = 7;

  // Scan selector codes
  localparam logic [1:0] SCAN_UPWARD   = 2'h0;
  localparam logic [1:0] SCAN_REPEAT8  = 2'h1;
  localparam logic [1:0] SCAN_FROM_MID = 2'h2;
  localparam logic [1:0] SCAN_SINGLE   = 2'h3;

  // Channel codes
  localparam logic [3:0] CH_GND          = 4'hf;
  localparam logic [3:0] CODE_LAST_VALID = 4'hb;
  localparam logic [3:0] MID_START_12    = 4'h6;
  localparam logic [3:0] MID_START_4     = 4'h2;
  localparam logic [3:0] REPEAT_COUNT    = 4'h8;

  // Reference select values
  localparam logic [2:0] SEL_AUTO_DOWN = 3'h4;
  localparam logic [2:0] SEL_INT_ON    = 3'h5;
  localparam logic [1:0] SEL_HI_OUTPUT = 2'h3;
  localparam int         SEL_MID_BIT   = 1;

  // Configuration byte, bits 6 down to 0
  typedef struct packed {
    logic scan_select_hi;
    logic scan_select_lo;
    logic channel_select_b3;
    logic channel_select_b2;
    logic channel_select_b1;
    logic channel_select_b0;
    logic single_ended_select;
  } acc_cfg_s;

  // Scan 00, channel 0, single-ended
  localparam acc_cfg_s CFG_RESET = 7'h01;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } acc_state_e;

  // Whole state of the control block
  typedef struct packed {
    acc_state_e state;
    acc_cfg_s   cfg;
    logic [3:0] code;
    logic [3:0] first;
    logic [3:0] last;
    logic [3:0] reps;
    logic [3:0] reps_load;
    logic       multi;
    logic       sgl;
    logic       conv_req;
    logic [3:0] pos;
    logic [3:0] neg;
    logic [3:0] wr_index;
    logic       analog_on;
    logic       ref_on;
    logic       results_ready;
    logic       reserved_code;
    logic       setup_strobe;
    logic [7:0] setup_data;
  } acc_regs_s;

endpackage

// ==== tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import acc_pkg::*;
  logic i_clock, i_reset_n, ev_byte, ev_addr, ev_read, ev_stop, ev_rst, ev_nack;
  logic i_ext_clock, i_conv_done, single, strobe, conv_req, reserved, analog_on;
  logic ref_on, ready;
  logic [7:0] ev_data, setup_data, b;
  logic [6:0] c, old;
  logic [2:0] i_ref_select;
  logic [1:0] scan_mode;
  logic [3:0] chan, pos, neg, windex;
  logic [3:0] widx = 4'h0;
  logic ref_up = 1'b0;
  localparam int REF_SETTLE = 16000; // 80 us of 5 ns cycles
  logic [9:0] dir [6] = '{10'h050, 10'h045, 10'h2f7, 10'h3b6, 10'h117, 10'h22b};
  int error_cnt = 0, num_checks = 0, seed = 32'hb414, i, j;
  logic [7:0] q[$];
  acc_control acc_control_inst (.i_clock(i_clock), .i_reset_n(i_reset_n),
    .i_byte_valid(ev_byte), .i_byte_data(ev_data), .i_addr_valid(ev_addr),
    .i_addr_read(ev_read), .i_stop(ev_stop), .i_restart(ev_rst), .i_master_nack(ev_nack),
    .i_ref_select(i_ref_select), .i_ext_clock(i_ext_clock), .i_conv_done(i_conv_done),
    .o_scan_mode(scan_mode), .o_channel_select(chan), .o_single_ended(single),
    .o_setup_strobe(strobe), .o_setup_data(setup_data), .o_conv_req(conv_req),
    .o_pos_input(pos), .o_neg_input(neg), .o_write_index(windex), .o_reserved_code(reserved),
    .o_analog_on(analog_on), .o_ref_on(ref_on), .o_results_ready(ready));
  acc_master_model acc_master_model_inst (.i_clock(i_clock), .o_byte_valid(ev_byte),
    .o_byte_data(ev_data), .o_addr_valid(ev_addr), .o_addr_read(ev_read),
    .o_stop(ev_stop), .o_restart(ev_rst), .o_nack(ev_nack));
  // Clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  // Expected input pair for one channel code
  function automatic logic [7:0] pr(input logic [3:0] k, input logic s, input logic [2:0] sel);
    logic [3:0] p, n;
    p = k;
    n = s ? CH_GND : k ^ 4'h1;
    if (sel[SEL_MID_BIT] && p == CODE_LAST_VALID) p = CH_GND;
    if (sel[SEL_MID_BIT] && n == CODE_LAST_VALID) n = CH_GND;
    return {p, n};
  endfunction
  // Expected conversion sequence of a scan
  function automatic void build(input logic [6:0] cf, input logic [2:0] sel);
    logic [3:0] ch, k, lo;
    logic s;
    ch = cf[4:1];
    s = cf[0];
    q.delete();
    if (cf[5]) begin
      repeat (cf[6] ? 1 : 8) q.push_back(pr(ch, s, sel));
    end else begin
      lo = cf[6] ? MID_START_12 : 4'h0;
      if (!s) lo = {lo[3:1], ch[0]};
      for (k = lo; k <= ((ch > lo) ? ch : lo); k += (s ? 4'h1 : 4'h2)) begin
        if (sel[SEL_MID_BIT] && (s ? k == CODE_LAST_VALID : k >= 4'ha)) break;
        q.push_back(pr(k, s, sel));
      end
    end
  endfunction
  // One converter completion pulse
  task automatic done_pulse();
    @(negedge i_clock);
    `CHK("wr_index", widx, windex)
    i_conv_done = 1'b1;
    @(negedge i_clock);
    i_conv_done = 1'b0;
    // Result memory wraps after twelve slots
    widx = (widx == 4'hb) ? 4'h0 : widx + 4'h1;
  endtask
  // Internal-clock read scan with power checks
  task automatic run_scan(input logic [6:0] cf, input logic [2:0] sel);
    int k;
    i_ref_select = sel;
    build(cf, sel);
    acc_master_model_inst.write_byte({1'b0, cf}, 1'b1);
    if (sel[2:1] == SEL_HI_OUTPUT && !ref_up) begin
      repeat (REF_SETTLE) @(negedge i_clock);
      ref_up = 1'b1;
    end
    acc_master_model_inst.read_addr(1'b1);
    for (k = 0; k < q.size(); k++) begin
      `CHK("conv_req", 1'b1, conv_req)
      `CHK("inputs", q[k], {pos, neg})
      done_pulse();
    end
    @(negedge i_clock);
    `CHK("conv_req", 1'b0, conv_req)
    `CHK("ready", 1'b1, ready)
    `CHK("analog", sel != SEL_AUTO_DOWN, analog_on)
    `CHK("ref_on", sel == SEL_INT_ON || sel[2:1] == SEL_HI_OUTPUT, ref_on)
    acc_master_model_inst.stop_cond();
    `CHK("ready", 1'b0, ready)
  endtask
  // Verdict and end of run
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #(5 * 40000);
    error_cnt++;
    give_verdict();
  end
  // Main sequence
  initial begin
    {i_reset_n, i_ext_clock, i_conv_done, i_ref_select} = 6'h00;
    repeat (20) @(negedge i_clock);
    i_reset_n = 1'b1;
    `CHK("cfg", 7'h01, {scan_mode, chan, single})
    `CHK("idle", 11'h03e, {conv_req, pos, neg, analog_on, ref_on})
    `CHK("ready", 1'b0, ready)
    for (i = 0; i < 40; i++) begin
      b = $random(seed);
      old = {scan_mode, chan, single};
      acc_master_model_inst.write_byte(b, 1'b1);
      `CHK("strobe", b[BYTE_TYPE_BIT], strobe)
      if (b[BYTE_TYPE_BIT]) begin
        `CHK("setup", b, setup_data)
      end
      `CHK("cfg", b[BYTE_TYPE_BIT] ? old : b[6:0], {scan_mode, chan, single})
      old = {scan_mode, chan, single};
      acc_master_model_inst.write_byte(~b, 1'b0);
      `CHK("partial", old, {scan_mode, chan, single})
      `CHK("strobe", 1'b0, strobe)
    end
    for (i = 12; i < 16; i++) begin
      acc_master_model_inst.write_byte({3'h3, i[3:0], i[0]}, 1'b1);
      acc_master_model_inst.read_addr(1'b1);
      `CHK("reserved", 2'h2, {reserved, conv_req})
      acc_master_model_inst.stop_cond();
    end
    for (i = 0; i < 6; i++) run_scan(dir[i][6:0], dir[i][9:7]);
    for (i = 0; i < 30; i++) begin
      c = $random(seed);
      c[4:1] = c[4:1] % 4'hc;
      run_scan(c, 3'($random(seed)));
    end
    i_ext_clock = 1'b1;
    i_ref_select = SEL_AUTO_DOWN;
    for (j = 0; j < 2; j++) begin
      acc_master_model_inst.write_byte({1'b0, j[0], 1'b1, 4'h5, 1'b1}, 1'b1);
      acc_master_model_inst.read_addr(1'b1);
      repeat (10) begin
        `CHK("ext_pos", 4'h5, pos)
        done_pulse();
      end
      `CHK("ext_run", 2'h3, {conv_req, ready})
      acc_master_model_inst.nack_ev();
      `CHK("ext_nack", 2'h1, {conv_req, analog_on})
      if (j == 1) begin
        acc_master_model_inst.restart_ev();
        `CHK("ready", 1'b0, ready)
      end
      acc_master_model_inst.stop_cond();
      @(negedge i_clock);
      `CHK("asleep", 1'b0, analog_on)
      acc_master_model_inst.read_addr(1'b0);
      `CHK("wake", 1'b1, analog_on)
      acc_master_model_inst.stop_cond();
    end
    give_verdict();
  end
endmodule
`default_nettype wire
